// >>> rtl/rxd_map.vh
// Register offsets, field positions, reset values and frame sizes of the receive control decode
`ifndef RXD_MAP_VH
`define RXD_MAP_VH

// Serial frame: address first, then data, both MSB first
`define RXD_ADDR_W          5
`define RXD_DATA_W          27
`define RXD_FRAME_BITS      6'h20

// Register addresses
`define RXD_ADDR_GPO        5'h07
`define RXD_ADDR_GENERAL_OUTPUT_ONE       5'h17
`define RXD_ADDR_TX_REF     5'h1D
`define RXD_ADDR_RX_GAIN    5'h02
`define RXD_ADDR_BASEBAND_CLOCK_OUTPUT_REGISTER  5'h03
`define RXD_ADDR_MODE       5'h04

// Field positions
`define RXD_GENERAL_OUTPUT_TWO_HI         3
`define RXD_GENERAL_OUTPUT_TWO_LO         2
`define RXD_GENERAL_OUTPUT_THREE_LEVEL      4
`define RXD_GENERAL_OUTPUT_THREE_LOCK_SEL   5
`define RXD_GENERAL_OUTPUT_ONE_HI         25
`define RXD_GENERAL_OUTPUT_ONE_LO         24
`define RXD_REF_SOFT_EN     14
`define RXD_REF_TYPE_SEL    23
`define RXD_LNA_HI          15
`define RXD_LNA_LO          14
`define RXD_PGA_HI          11
`define RXD_PGA_LO          8
`define RXD_INSEL_HI        2
`define RXD_INSEL_LO        0
`define RXD_LVDS_DRIVE      0
`define RXD_MODE_GSM        0

// Input selection codes
`define RXD_IN_MAIN         3'h1
`define RXD_IN_MON_A        3'h2
`define RXD_IN_MON_B        3'h4
`define RXD_IN_MON_C        3'h5

// LNA gain codes
`define RXD_LNA_HIGH        2'h0
`define RXD_LNA_MED         2'h1
`define RXD_LNA_LOW         2'h2

// PGA step size in dB
`define RXD_PGA_STEP_DB     6'h03

// Reset values
`define RXD_GPO_RST         27'h0000000
`define RXD_GENERAL_OUTPUT_ONE_RST        27'h0000000
`define RXD_TX_REF_RST      27'h0000000
`define RXD_RX_GAIN_RST     27'h0000001
`define RXD_BASEBAND_CLOCK_OUTPUT_REGISTER_RST   27'h0000001
`define RXD_MODE_RST        27'h0000000

`endif

// >>> rtl/rxd_serial_rx.v
// Serial control port receiver: pin synchronisers and frame shifter
`timescale 1ns/10ps
`include "rxd_map.vh"
module rxd_serial_rx (
    input  wire                    clock,
    input  wire                    nrst,
    input  wire                    ce,
    input  wire                    ser_clk,
    input  wire                    ser_cs_n,
    input  wire                    ser_din,
    output reg                     wr_strobe_reg,
    output reg  [`RXD_ADDR_W-1:0]  wr_addr_reg,
    output reg  [`RXD_DATA_W-1:0]  wr_data_reg
);
    reg  [2:0]  sclk_sync_reg;
    reg  [2:0]  cs_sync_reg;
    reg  [2:0]  din_sync_reg;
    reg         sclk_reg;
    reg         cs_n_reg;
    reg         din_reg;
    reg  [5:0]  count_reg;
    reg  [31:0] shift_reg;
    wire        sclk_rise;
    wire [31:0] shift_next;

    // Three-stage synchronisers; a level counts once stages two and three agree
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 3'h7;
            din_sync_reg  <= 3'h0;
            sclk_reg      <= 1'b0;
            cs_n_reg      <= 1'b1;
            din_reg       <= 1'b0;
        end else if (ce) begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk};
            cs_sync_reg   <= {cs_sync_reg[1:0], ser_cs_n};
            din_sync_reg  <= {din_sync_reg[1:0], ser_din};
            if (sclk_sync_reg[1] == sclk_sync_reg[2])
                sclk_reg <= sclk_sync_reg[2];
            if (cs_sync_reg[1] == cs_sync_reg[2])
                cs_n_reg <= cs_sync_reg[2];
            if (din_sync_reg[1] == din_sync_reg[2])
                din_reg <= din_sync_reg[2];
        end
    end

    // Data is filtered one stage behind the clock, so it is sampled settled at the edge
    assign sclk_rise  = (sclk_sync_reg[2] == sclk_sync_reg[1]) && sclk_sync_reg[2] && !sclk_reg;
    assign shift_next = {shift_reg[30:0], din_reg};

    // Shift on each rising serial clock; a frame ends on its last bit
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count_reg     <= 6'h00;
            shift_reg     <= 32'h00000000;
            wr_strobe_reg <= 1'b0;
            wr_addr_reg   <= {`RXD_ADDR_W{1'b0}};
            wr_data_reg   <= {`RXD_DATA_W{1'b0}};
        end else if (ce) begin
            wr_strobe_reg <= 1'b0;
            if (cs_n_reg) begin
                count_reg <= 6'h00; // Deselect drops a partial frame
            end else if (sclk_rise) begin
                shift_reg <= shift_next;
                if (count_reg == `RXD_FRAME_BITS - 6'h01) begin
                    count_reg     <= 6'h00;
                    wr_strobe_reg <= 1'b1;
                    wr_addr_reg   <= shift_next[31:27];
                    wr_data_reg   <= shift_next[26:0];
                end else begin
                    count_reg <= count_reg + 6'h01;
                end
            end
        end
    end
endmodule // rxd_serial_rx

// >>> rtl/rxd_rx_control.v
// Receive path control decode: serial registers, gain, input, reference and GPO decode, bitstream out
`timescale 1ns/10ps
module rxd_rx_control (
    input  wire        clock,
    input  wire        nrst,
    input  wire        ce,
    input  wire        ser_clk,
    input  wire        ser_cs_n,
    input  wire        ser_din,
    input  wire        ref_buffer_enable_pin,
    input  wire        synth_lock,
    input  wire        mod_sample_valid,
    input  wire        mod_bit_i,
    input  wire        mod_bit_q,
    output reg         general_output_one,
    output reg         general_output_one_oe_n,
    output reg         general_output_two,
    output reg         general_output_two_oe_n,
    output reg         general_output_three,
    output reg         ref_clock_output_on,
    output reg         ref_clock_output_low_voltage,
    output reg  [2:0]  rx_input_select,
    output reg         rx_monitor_active,
    output reg  [1:0]  lna_gain_code,
    output reg  [3:0]  baseband_amp_gain_code,
    output reg  [5:0]  baseband_amp_gain_db,
    output reg         lvds_drive_current_select,
    output reg         adc_rate_gsm,
    output reg         rx_bitstream_i,
    output reg         rx_bitstream_q
);
    `include "rxd_map.vh"

    wire                    wr_strobe;
    wire [`RXD_ADDR_W-1:0]  wr_addr;
    wire [`RXD_DATA_W-1:0]  wr_data;

    reg  [`RXD_DATA_W-1:0]  gpo_reg;
    reg  [`RXD_DATA_W-1:0]  general_output_one_reg;
    reg  [`RXD_DATA_W-1:0]  tx_synth_reference_register_reg;
    reg  [`RXD_DATA_W-1:0]  rx_gain_reg;
    reg  [`RXD_DATA_W-1:0]  baseband_clock_output_register_reg;
    reg  [`RXD_DATA_W-1:0]  mode_reg;
    reg  [2:0]              ref_buffer_enable_pin_sync_reg;
    reg  [2:0]              lock_sync_reg;
    reg                     ref_buffer_enable_pin_reg;
    reg                     lock_reg;
    reg  [2:0]              insel_next;
    reg  [1:0]              lna_next;
    reg  [1:0]              gpo_one_next;
    reg  [1:0]              gpo_two_next;
    reg  [1:0]              ref_next;

    // Receive input limited to legal codes; others fall back to the main input
    function [2:0] rxd_input_decode;
        input [2:0] code;
        begin
            case (code)
                `RXD_IN_MAIN:  rxd_input_decode = `RXD_IN_MAIN;
                `RXD_IN_MON_A: rxd_input_decode = `RXD_IN_MON_A;
                `RXD_IN_MON_B: rxd_input_decode = `RXD_IN_MON_B;
                `RXD_IN_MON_C: rxd_input_decode = `RXD_IN_MON_C;
                default:       rxd_input_decode = `RXD_IN_MAIN;
            endcase
        end
    endfunction

    // Gain code legal for the chosen input; input 4 has no medium state
    function [1:0] rxd_lna_decode;
        input [2:0] insel;
        input [1:0] code;
        begin
            case (code)
                `RXD_LNA_HIGH: rxd_lna_decode = `RXD_LNA_HIGH;
                `RXD_LNA_MED:  rxd_lna_decode = (insel == `RXD_IN_MON_B) ? `RXD_LNA_LOW : `RXD_LNA_MED;
                default:       rxd_lna_decode = `RXD_LNA_LOW;
            endcase
        end
    endfunction

    // Reference mode as {on, low voltage}; the strap wins so the clock exists before any serial write
    function [1:0] rxd_ref_decode;
        input strap;
        input soft_en;
        input type_sel;
        begin
            if (strap)
                rxd_ref_decode = 2'h2;
            else if (!soft_en)
                rxd_ref_decode = 2'h0;
            else
                rxd_ref_decode = {1'b1, type_sel};
        end
    endfunction

    // Output pin field as {level, release}; a set high bit lets the pin float
    function [1:0] rxd_gpo_decode;
        input [1:0] field;
        begin
            rxd_gpo_decode = {field[0], field[1]};
        end
    endfunction

    // Serial frame receiver
    rxd_serial_rx u_serial (
        .clock         (clock),
        .nrst          (nrst),
        .ce            (ce),
        .ser_clk       (ser_clk),
        .ser_cs_n      (ser_cs_n),
        .ser_din       (ser_din),
        .wr_strobe_reg (wr_strobe),
        .wr_addr_reg   (wr_addr),
        .wr_data_reg   (wr_data)
    );

    // Register file; writes to unknown addresses are dropped
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gpo_reg                            <= `RXD_GPO_RST;
            general_output_one_reg                           <= `RXD_GENERAL_OUTPUT_ONE_RST;
            tx_synth_reference_register_reg    <= `RXD_TX_REF_RST;
            rx_gain_reg                        <= `RXD_RX_GAIN_RST;
            baseband_clock_output_register_reg <= `RXD_BASEBAND_CLOCK_OUTPUT_REGISTER_RST;
            mode_reg                           <= `RXD_MODE_RST;
        end else if (ce && wr_strobe) begin
            case (wr_addr)
                `RXD_ADDR_GPO:       gpo_reg                            <= wr_data;
                `RXD_ADDR_GENERAL_OUTPUT_ONE:      general_output_one_reg                           <= wr_data;
                `RXD_ADDR_TX_REF:    tx_synth_reference_register_reg    <= wr_data;
                `RXD_ADDR_RX_GAIN:   rx_gain_reg                        <= wr_data;
                `RXD_ADDR_BASEBAND_CLOCK_OUTPUT_REGISTER: baseband_clock_output_register_reg <= wr_data;
                `RXD_ADDR_MODE:      mode_reg                           <= wr_data;
                default:             mode_reg                           <= mode_reg;
            endcase
        end
    end

    // Pin synchronisers for the reference enable strap and synthesizer lock
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ref_buffer_enable_pin_sync_reg <= 3'h0;
            lock_sync_reg  <= 3'h0;
            ref_buffer_enable_pin_reg      <= 1'b0;
            lock_reg       <= 1'b0;
        end else if (ce) begin
            ref_buffer_enable_pin_sync_reg <= {ref_buffer_enable_pin_sync_reg[1:0], ref_buffer_enable_pin};
            lock_sync_reg  <= {lock_sync_reg[1:0], synth_lock};
            if (ref_buffer_enable_pin_sync_reg[1] == ref_buffer_enable_pin_sync_reg[2])
                ref_buffer_enable_pin_reg <= ref_buffer_enable_pin_sync_reg[2];
            if (lock_sync_reg[1] == lock_sync_reg[2])
                lock_reg <= lock_sync_reg[2];
        end
    end

    // Input and gain legalisation ahead of the output flops
    always @* begin
        insel_next = rxd_input_decode(rx_gain_reg[`RXD_INSEL_HI:`RXD_INSEL_LO]);
        lna_next   = rxd_lna_decode(insel_next, rx_gain_reg[`RXD_LNA_HI:`RXD_LNA_LO]);
        gpo_one_next = rxd_gpo_decode(general_output_one_reg[`RXD_GENERAL_OUTPUT_ONE_HI:`RXD_GENERAL_OUTPUT_ONE_LO]);
        gpo_two_next = rxd_gpo_decode(gpo_reg[`RXD_GENERAL_OUTPUT_TWO_HI:`RXD_GENERAL_OUTPUT_TWO_LO]);
        ref_next     = rxd_ref_decode(ref_buffer_enable_pin_reg,
                                      tx_synth_reference_register_reg[`RXD_REF_SOFT_EN],
                                      tx_synth_reference_register_reg[`RXD_REF_TYPE_SEL]);
    end

    // Decoded control outputs, one cycle after the register write
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            general_output_one           <= 1'b0;
            general_output_one_oe_n      <= 1'b1;
            general_output_two           <= 1'b0;
            general_output_two_oe_n      <= 1'b1;
            general_output_three         <= 1'b0;
            ref_clock_output_on          <= 1'b0;
            ref_clock_output_low_voltage <= 1'b0;
            rx_input_select              <= `RXD_IN_MAIN;
            rx_monitor_active            <= 1'b0;
            lna_gain_code                <= `RXD_LNA_HIGH;
            baseband_amp_gain_code       <= 4'h0;
            baseband_amp_gain_db         <= 6'h00;
            lvds_drive_current_select    <= 1'b1;
            adc_rate_gsm                 <= 1'b0;
        end else if (ce) begin
            // Output pin fields decoded ahead as {level, release}
            general_output_one      <= gpo_one_next[1];
            general_output_one_oe_n <= gpo_one_next[0];
            general_output_two      <= gpo_two_next[1];
            general_output_two_oe_n <= gpo_two_next[0];
            general_output_three    <= gpo_reg[`RXD_GENERAL_OUTPUT_THREE_LOCK_SEL] ? lock_reg : gpo_reg[`RXD_GENERAL_OUTPUT_THREE_LEVEL];
            // Reference mode decoded ahead as {on, low voltage}
            ref_clock_output_on          <= ref_next[1];
            ref_clock_output_low_voltage <= ref_next[0];
            rx_input_select        <= insel_next;
            rx_monitor_active      <= (insel_next != `RXD_IN_MAIN);
            lna_gain_code          <= lna_next;
            baseband_amp_gain_code <= rx_gain_reg[`RXD_PGA_HI:`RXD_PGA_LO];
            baseband_amp_gain_db   <= {2'h0, rx_gain_reg[`RXD_PGA_HI:`RXD_PGA_LO]} * `RXD_PGA_STEP_DB;
            lvds_drive_current_select <= baseband_clock_output_register_reg[`RXD_LVDS_DRIVE];
            adc_rate_gsm           <= mode_reg[`RXD_MODE_GSM];
        end
    end

    // Bitstream pass-through: samples retimed, no coding, no clock leaves the block
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rx_bitstream_i <= 1'b0;
            rx_bitstream_q <= 1'b0;
        end else if (ce && mod_sample_valid) begin
            rx_bitstream_i <= mod_bit_i;
            rx_bitstream_q <= mod_bit_q;
        end
    end
endmodule // rxd_rx_control

// >>> dv/rxd_rx_control_sva.sv
// Assertions on the ports of the receive control decode
`timescale 1ns/10ps
module rxd_rx_control_sva (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       ce,
    input wire logic       ser_cs_n,
    input wire logic       ref_buffer_enable_pin,
    input wire logic       mod_sample_valid,
    input wire logic       mod_bit_i,
    input wire logic       mod_bit_q,
    input wire logic       ref_clock_output_on,
    input wire logic       ref_clock_output_low_voltage,
    input wire logic [2:0] rx_input_select,
    input wire logic       rx_monitor_active,
    input wire logic [1:0] lna_gain_code,
    input wire logic [3:0] baseband_amp_gain_code,
    input wire logic [5:0] baseband_amp_gain_db,
    input wire logic       rx_bitstream_i,
    input wire logic       rx_bitstream_q
);
    logic [3:0] sel_age_reg;

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Cycles since chip select was last low; decoded gains may only move near a frame end
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_age_reg <= 4'hF;
        end else if (!ser_cs_n) begin
            sel_age_reg <= 4'h0;
        end else if (sel_age_reg != 4'hF) begin
            sel_age_reg <= sel_age_reg + 4'h1;
        end
    end

    sequence s_taken;
        ce && mod_sample_valid;
    endsequence

    sequence s_strap_held;
        (ce && ref_buffer_enable_pin) [*8];
    endsequence

    AST_SAMPLE_PASS: assert property (
        s_taken |=> rx_bitstream_i == $past(mod_bit_i) && rx_bitstream_q == $past(mod_bit_q))
        else $error("bitstream does not carry the taken sample");
    AST_SAMPLE_HOLD: assert property (
        !(ce && mod_sample_valid) |=> $stable(rx_bitstream_i) && $stable(rx_bitstream_q))
        else $error("bitstream moved without a sample");
    AST_STRAP_CMOS: assert property (
        s_strap_held |-> ref_clock_output_on && !ref_clock_output_low_voltage)
        else $error("strap high but reference output not CMOS");
    AST_INPUT_LEGAL: assert property (
        rx_input_select inside {3'h1, 3'h2, 3'h4, 3'h5})
        else $error("receive input select holds an unused code");
    AST_MONITOR_FLAG: assert property (
        rx_monitor_active == (rx_input_select != 3'h1))
        else $error("monitor flag disagrees with input select");
    AST_LNA_STATES: assert property (
        lna_gain_code != 2'h3 && !(rx_input_select == 3'h4 && lna_gain_code == 2'h1))
        else $error("LNA state not offered by the selected input");
    AST_PGA_DB: assert property (
        baseband_amp_gain_db == {1'b0, baseband_amp_gain_code, 1'b0} + {2'h0, baseband_amp_gain_code})
        else $error("amplifier gain in dB is not three per step");
    AST_GAIN_AT_FRAME_END: assert property (
        ($changed(lna_gain_code) || $changed(baseband_amp_gain_code)) |-> sel_age_reg < 4'hC)
        else $error("gain changed away from a serial frame");
endmodule // rxd_rx_control_sva

// >>> dv/rxd_bb_model.sv
// Baseband-side model that receives the two sigma-delta bitstreams
`timescale 1ns/10ps
module rxd_bb_model (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        line_i,
    input wire logic        line_q,
    output logic     [1:0]  pair_reg,
    output logic     [7:0]  density_reg
);
    // No clock arrives with the data, so the lines are sampled on the local clock
    // Crude leaky density count stands in for the digital channel filter
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pair_reg <= 2'h0;
            density_reg <= 8'h00;
        end else begin
            pair_reg <= {line_i, line_q};
            density_reg <= density_reg - {4'h0, density_reg[7:4]} + {line_i, 4'h0};
        end
    end
endmodule // rxd_bb_model

// >>> dv/test_rx_bitstream_and_control_decode.sv
// Self-checking bench for the receive control decode
`timescale 1ns/10ps
`include "rxd_map.vh"
module test_rx_bitstream_and_control_decode;
    logic        clock, nrst, ce, ser_clk, ser_cs_n, ser_din;
    logic        strap, lock, valid, bit_i, bit_q, v1, v2;
    logic [26:0] r7, r17, r1d, r2, r3, r4;
    logic [2:0]  codes [5];
    logic [31:0] notes [$];
    wire  [24:0] seen;
    wire  [1:0]  bs, pair;
    int          failures, n_checks, cycles;
    event        snap_ev;

    rxd_rx_control dut (.clock(clock), .nrst(nrst), .ce(ce), .ser_clk(ser_clk), .ser_cs_n(ser_cs_n),
        .ser_din(ser_din), .ref_buffer_enable_pin(strap), .synth_lock(lock), .mod_sample_valid(valid),
        .mod_bit_i(bit_i), .mod_bit_q(bit_q), .general_output_one(seen[24]), .general_output_one_oe_n(seen[23]),
        .general_output_two(seen[22]), .general_output_two_oe_n(seen[21]), .general_output_three(seen[20]),
        .ref_clock_output_on(seen[19]), .ref_clock_output_low_voltage(seen[18]), .rx_input_select(seen[17:15]),
        .rx_monitor_active(seen[14]), .lna_gain_code(seen[13:12]), .baseband_amp_gain_code(seen[11:8]),
        .baseband_amp_gain_db(seen[7:2]), .lvds_drive_current_select(seen[1]), .adc_rate_gsm(seen[0]),
        .rx_bitstream_i(bs[1]), .rx_bitstream_q(bs[0]));
    rxd_bb_model bb (.clock(clock), .nrst(nrst), .line_i(bs[1]), .line_q(bs[0]), .pair_reg(pair),
        .density_reg());

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Expected decoded outputs from the mirrored register contents and the pins
    function automatic logic [24:0] expect_vec();
        logic [2:0] sel;
        logic [1:0] lna;
        sel = (r2[2:0] inside {3'h1, 3'h2, 3'h4, 3'h5}) ? r2[2:0] : 3'h1;
        lna = r2[15:14];
        if (lna == 2'h3 || (sel == 3'h4 && lna == 2'h1))
            lna = 2'h2;
        return {r17[24], r17[25], r7[2], r7[3], r7[5] ? lock : r7[4], strap | r1d[14],
            ~strap & r1d[14] & r1d[23], sel, sel != 3'h1, lna, r2[11:8], r2[11:8] * `RXD_PGA_STEP_DB, r3[0], r4[0]};
    endfunction

    task automatic snap();
        notes.push_back({7'h0, expect_vec()});
        ->snap_ev;
    endtask

    // One serial frame, address then data, most significant bit first; short frames are cut off
    task automatic ser_write(input logic [4:0] addr, input logic [26:0] data, input int nbits);
        logic [31:0] frame;
        frame = {addr, data};
        ser_cs_n = 1'b0;
        for (int b = 31; b > 31 - nbits; b--) begin
            tick(1);
            ser_din = frame[b];
            tick(5);
            ser_clk = 1'b1;
            tick(5);
            ser_clk = 1'b0;
        end
        tick(10);
        ser_cs_n = 1'b1;
        if (nbits == 32) begin
            case (addr)
                `RXD_ADDR_GPO: r7 = data;
                `RXD_ADDR_GENERAL_OUTPUT_ONE: r17 = data;
                `RXD_ADDR_TX_REF: r1d = data;
                `RXD_ADDR_RX_GAIN: r2 = data;
                `RXD_ADDR_BASEBAND_CLOCK_OUTPUT_REGISTER: r3 = data;
                `RXD_ADDR_MODE: r4 = data;
                default: ;
            endcase
        end
        tick(6);
        snap();
    endtask

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Sample notes fall due two edges on: design edge, then the model's capture
    always @(posedge clock) begin
        v1 <= valid & ce;
        v2 <= v1;
    end

    always @(posedge clock) begin
        #1;
        if (v2 === 1'b1)
            check({30'h0, pair}, notes.pop_front());
    end

    always @(snap_ev) begin
        check({7'h0, seen}, notes.pop_front());
    end

    // Hang guard, well above the roughly 20000 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        {nrst, ser_clk, ser_din, strap, lock, valid, bit_i, bit_q, v1, v2} = '0;
        ce = 1'b1;
        ser_cs_n = 1'b1;
        {r7, r17, r1d, r4} = '0;
        r2 = `RXD_RX_GAIN_RST;
        r3 = `RXD_BASEBAND_CLOCK_OUTPUT_REGISTER_RST;
        codes = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3};
        void'($urandom(67));
        tick(10);
        nrst = 1'b1;
        tick(10);
        snap();
        $display("Test reset values done");
        for (int k = 0; k < 16; k++) begin
            lock = 1'($urandom);
            ser_write(`RXD_ADDR_GPO, {21'h0, 4'(k), 2'(k)}, 32);
        end
        for (int k = 0; k < 4; k++)
            ser_write(`RXD_ADDR_GENERAL_OUTPUT_ONE, {1'b0, 2'(k), 24'($urandom)}, 32);
        $display("Test general outputs done");
        for (int k = 0; k < 8; k++) begin
            strap = k[2];
            ser_write(`RXD_ADDR_TX_REF, {3'h0, k[1], 8'h00, k[0], 14'h0}, 32);
        end
        strap = 1'b0;
        $display("Test reference output done");
        for (int k = 0; k < 20; k++)
            ser_write(`RXD_ADDR_RX_GAIN, {11'h0, 2'(k / 5), 2'h0, 4'($urandom), 5'h0, codes[k % 5]}, 32);
        $display("Test receive gain done");
        for (int k = 0; k < 2; k++) begin
            ser_write(`RXD_ADDR_BASEBAND_CLOCK_OUTPUT_REGISTER, {26'h0, k[0]}, 32);
            ser_write(`RXD_ADDR_MODE, {26'h0, ~k[0]}, 32);
        end
        ser_write(`RXD_ADDR_GPO, 27'h7FFFFFF, 10);
        ser_write(5'h1F, 27'h7FFFFFF, 32);
        $display("Test drive, mode and dropped frames done");
        // A second reset must bring every register back to its default
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        {r7, r17, r1d, r4} = '0;
        r2 = `RXD_RX_GAIN_RST;
        r3 = `RXD_BASEBAND_CLOCK_OUTPUT_REGISTER_RST;
        tick(10);
        snap();
        $display("Test second reset done");
        for (int k = 0; k < 40; k++) begin
            ce = (k < 4) | 1'($urandom); // Frozen cycles must neither take nor lose a sample
            valid = (k < 4) | 1'($urandom);
            bit_i = 1'($urandom);
            bit_q = 1'($urandom);
            if (valid & ce)
                notes.push_back({30'h0, bit_i, bit_q});
            tick(1);
        end
        valid = 1'b0;
        ce = 1'b1;
        tick(5);
        $display("Test bitstream done");
        test_done();
    end
endmodule // test_rx_bitstream_and_control_decode

bind rxd_rx_control rxd_rx_control_sva u_sva (.clock, .nrst, .ce, .ser_cs_n, .ref_buffer_enable_pin,
    .mod_sample_valid, .mod_bit_i, .mod_bit_q, .ref_clock_output_on, .ref_clock_output_low_voltage,
    .rx_input_select, .rx_monitor_active, .lna_gain_code, .baseband_amp_gain_code, .baseband_amp_gain_db,
    .rx_bitstream_i, .rx_bitstream_q);
